// ---- src/dual_timer_counter.sv ----
// two timer/counters with machine-cycle phasing and external count pins
// assumes the cpu writes bytes through strobes on mclk and pins are asynchronous
// ***********************************************
// Functional notes
// - two 16-bit counters each made of a high byte and a low byte written separately.
// - timer function counts a tick of the clock divided by twelve or by four.
// - count pins are sampled at sample_phase and a high then low sample is one falling edge.
// - counts change at update_phase, edges from one machine cycle count in the next.
// - function select comes from mode register bit 2 for counter 0 and bit 6 for counter 1.
// - each counter has a two-bit mode select field in the mode register.
// - time-base bits reset to zero for divide by twelve and give divide by four when one.
// - mode 0 is a 13-bit counter of eight high bits and five low bits, upper low bits ignored.
// - in mode 0 the high byte increments when low bit 4 falls from one to zero.
// - the overflow flag sets when the high byte rolls over from ff to 00.
// - counting happens only while the run control bit is set, otherwise the count holds.
// - the overflow flag clears when the cpu vectors to that counter's service routine.
// ***********************************************
module dual_timer_counter
    import tmr_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // register writes
    input  wire logic [7:0] wr_data,
    input  wire logic       counter_mode_register_wr,
    input  wire logic       clock_control_register_wr,
    input  wire logic       cnt0_high_byte_wr,
    input  wire logic       cnt0_low_byte_wr,
    input  wire logic       cnt1_high_byte_wr,
    input  wire logic       cnt1_low_byte_wr,
    // run control and interrupt acknowledge
    input  wire logic       run_control_bit_0,
    input  wire logic       run_control_bit_1,
    input  wire logic       vector_ack_0,
    input  wire logic       vector_ack_1,
    // external count pins
    input  wire logic       count_pin_0,
    input  wire logic       count_pin_1,
    // state
    output logic [7:0]      cnt0_high_byte,
    output logic [7:0]      cnt0_low_byte,
    output logic [7:0]      cnt1_high_byte,
    output logic [7:0]      cnt1_low_byte,
    output logic [7:0]      counter_mode_register,
    output logic [7:0]      clock_control_register,
    output logic            overflow_flag_0,
    output logic            overflow_flag_1
);
    import tmr_pkg::*;

    // a standard machine cycle spends three clocks in each of its four phases
    localparam logic [3:0] PH_CLKS_STD = 4'h3;

    // ***********************************************
    // configuration registers
    // ***********************************************
    logic [7:0] mode_reg;
    logic [7:0] ck_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_reg <= BYTE_RST;
        end else if (counter_mode_register_wr) begin
            mode_reg <= wr_data;
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ck_reg <= BYTE_RST;
        end else if (clock_control_register_wr) begin
            ck_reg <= wr_data;
        end
    end
    assign counter_mode_register  = mode_reg;
    assign clock_control_register = ck_reg;

    // ***********************************************
    // pin synchronisers
    // ***********************************************
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    // flops reset low; the edge detector also resets low, so no false fall follows reset
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
        end else begin
            pin_s1 <= {count_pin_1, count_pin_0};
            pin_s2 <= pin_s1;
        end
    end

    // ***********************************************
    // counter channels
    // ***********************************************
    logic [1:0] ch_ovf;
    for (genvar i = 0; i < 2; i++) begin : g_ch
        logic [7:0] hi_reg;
        logic [7:0] lo_reg;
        logic [7:0] hi_next;
        logic [7:0] lo_next;
        logic [3:0] div_reg;
        logic [1:0] ph;
        logic       samp_reg;
        logic       edge_reg;
        logic       flag_reg;
        logic       turbo;
        logic       is_cnt;
        logic       run;
        logic       tick;
        logic       roll;
        logic [3:0] last;
        cnt_mode_t  mode;
        logic       wr_hi;
        logic       wr_lo;

        assign turbo = ck_reg[i == 0 ? CK_TB0_BIT : CK_TB1_BIT];
        assign is_cnt = mode_reg[i == 0 ? MODE_CT0_BIT : MODE_CT1_BIT];
        assign mode = cnt_mode_t'(mode_reg[(i == 0 ? MODE_M0_0 : MODE_M0_1) +: 2]);
        assign run = (i == 0) ? run_control_bit_0 : run_control_bit_1;
        assign wr_hi = (i == 0) ? cnt0_high_byte_wr : cnt1_high_byte_wr;
        assign wr_lo = (i == 0) ? cnt0_low_byte_wr : cnt1_low_byte_wr;
        // machine cycle length follows the time base, turbo cycles are 4 clocks
        assign last = turbo ? MC_LAST_TURBO : MC_LAST_STD;
        // phase index within a cycle of 12 spans three clocks, of 4 one clock
        assign ph = turbo ? div_reg[1:0] : 2'(div_reg / PH_CLKS_STD);
        // the divider runs free, so the first tick after run rises may fall anywhere in a cycle

        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                div_reg <= 4'h0;
            end else if (div_reg >= last) begin
                div_reg <= 4'h0;
            end else begin
                div_reg <= div_reg + 4'h1;
            end
        end

        // one sample per machine cycle at sample_phase; edge held for the next update
        logic samp_now;
        logic upd_now;
        assign samp_now = (ph == PH_SAMPLE) && (turbo || (div_reg % PH_CLKS_STD) == 4'h0);
        assign upd_now  = (ph == PH_UPDATE) && (turbo || (div_reg % PH_CLKS_STD) == 4'h0);
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                samp_reg <= 1'b0;
                edge_reg <= 1'b0;
            end else if (samp_now) begin
                samp_reg <= pin_s2[i];
                edge_reg <= samp_reg & ~pin_s2[i];
            end else if (upd_now) begin
                edge_reg <= 1'b0;
            end
        end

        // edge sampled in the previous cycle is consumed at this cycle's update_phase
        assign tick = upd_now && run && (is_cnt ? edge_reg : 1'b1);

        always_comb begin
            hi_next = hi_reg;
            lo_next = lo_reg;
            roll    = 1'b0;
            unique case (mode)
                MODE_13BIT: begin
                    lo_next = {lo_reg[7:5], lo_reg[4:0] + 5'h1};
                    if (lo_reg[PRE_MSB:0] == PRE_ONES) begin
                        hi_next = hi_reg + 8'h1;
                        roll    = (hi_reg == BYTE_ONES);
                    end
                end
                MODE_16BIT, MODE_RELOAD, MODE_SPLIT: begin
                    // modes above 0 run as a plain 16-bit count here
                    lo_next = lo_reg + 8'h1;
                    if (lo_reg == BYTE_ONES) begin
                        hi_next = hi_reg + 8'h1;
                        roll    = (hi_reg == BYTE_ONES);
                    end
                end
            endcase
        end

        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                hi_reg <= BYTE_RST;
                lo_reg <= BYTE_RST;
            end else begin
                // software byte writes take priority over a count in the same clock
                // the tick is then lost for the written byte only; the other byte still moves
                if (wr_hi) begin
                    hi_reg <= wr_data;
                end else if (tick) begin
                    hi_reg <= hi_next;
                end
                if (wr_lo) begin
                    lo_reg <= wr_data;
                end else if (tick) begin
                    lo_reg <= lo_next;
                end
            end
        end

        // set wins over the vectoring clear
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                flag_reg <= 1'b0;
            end else if (tick && roll) begin
                flag_reg <= 1'b1;
            end else if ((i == 0) ? vector_ack_0 : vector_ack_1) begin
                flag_reg <= 1'b0;
            end
        end
        assign ch_ovf[i] = flag_reg;
    end

    assign cnt0_high_byte  = g_ch[0].hi_reg;
    assign cnt0_low_byte   = g_ch[0].lo_reg;
    assign cnt1_high_byte  = g_ch[1].hi_reg;
    assign cnt1_low_byte   = g_ch[1].lo_reg;
    assign overflow_flag_0 = ch_ovf[0];
    assign overflow_flag_1 = ch_ovf[1];
endmodule

// ---- src/tmr_pkg.sv ----
// constants for the dual timer/counter block
// assumes a single mclk domain and byte-wide special function register writes
package tmr_pkg;
    // ***********************************************
    // machine cycle and phases
    // ***********************************************
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned MC_LEN_STD    = 12;
    localparam int unsigned MC_LEN_TURBO  = 4;
    localparam logic [3:0]  MC_LAST_STD   = 4'(MC_LEN_STD - 1);
    localparam logic [3:0]  MC_LAST_TURBO = 4'(MC_LEN_TURBO - 1);
    localparam logic [1:0]  PH_UPDATE     = 2'h2;  // update_phase, third phase of the cycle
    localparam logic [1:0]  PH_SAMPLE     = 2'h3;  // sample_phase, fourth phase of the cycle
    // ***********************************************
    // register fields
    // ***********************************************
    localparam int unsigned MODE_CT0_BIT  = 2;
    localparam int unsigned MODE_CT1_BIT  = 6;
    localparam int unsigned MODE_M0_0     = 0;
    localparam int unsigned MODE_M0_1     = 4;
    localparam int unsigned CK_TB0_BIT    = 3;
    localparam int unsigned CK_TB1_BIT    = 4;
    localparam logic [7:0]  BYTE_RST      = 8'h00;
    localparam logic [7:0]  BYTE_ONES     = 8'hff;
    localparam logic [4:0]  PRE_ONES      = 5'h1f;
    localparam int unsigned PRE_MSB       = 4;
    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } cnt_mode_t;
endpackage

// ---- bench/dual_timer_counter_properties.sv ----
// checker on the ports of the dual timer/counter
// assumes one mclk domain, bound from the testbench
module dual_timer_counter_properties (
    input wire logic       mclk, rstn, counter_mode_register_wr, clock_control_register_wr,
    input wire logic       cnt0_high_byte_wr, cnt0_low_byte_wr, run_control_bit_0, vector_ack_0, vector_ack_1,
    input wire logic [7:0] wr_data, cnt0_high_byte, cnt0_low_byte, cnt1_high_byte,
    input wire logic [7:0] counter_mode_register, clock_control_register,
    input wire logic       overflow_flag_0, overflow_flag_1
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // port relations
    // ********
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    hi_write_a: assert property (cnt0_high_byte_wr |=> cnt0_high_byte == $past(wr_data))
        else $error("high byte write lost");
    mode_write_a: assert property (counter_mode_register_wr |=> counter_mode_register == $past(wr_data))
        else $error("mode write lost");
    base_write_a: assert property (clock_control_register_wr |=> clock_control_register == $past(wr_data))
        else $error("time base write lost");
    run_hold_a: assert property (!run_control_bit_0 && !cnt0_low_byte_wr |=> $stable(cnt0_low_byte))
        else $error("count moved while stopped");
    flag_set_a: assert property ($rose(overflow_flag_0) |-> cnt0_high_byte == 8'h00 && $past(cnt0_high_byte) == 8'hff)
        else $error("flag set without rollover");
    flag_clear_a: assert property (vector_ack_1 && cnt1_high_byte != 8'hff |=> !overflow_flag_1)
        else $error("flag kept after vector");
    ack_clear_a: assert property (vector_ack_0 && cnt0_high_byte != 8'hff |=> !overflow_flag_0)
        else $error("flag 0 kept after vector");
    upper_held_a: assert property (counter_mode_register[1:0] == 2'b00 && !cnt0_low_byte_wr |=> $stable(cnt0_low_byte[7:5]))
        else $error("ignored low bits moved");
    carry_a: assert property (counter_mode_register[1:0] == 2'b00 && $stable(counter_mode_register) &&
        !$past(cnt0_high_byte_wr) && $changed(cnt0_high_byte) |-> $fell(cnt0_low_byte[4]))
        else $error("high byte moved without carry");
endmodule

// ---- bench/pin_source.sv ----
// board logic driving one external count pin with a burst of falls
// assumes mclk of the block; the pin idles high as a pulled-up input
module pin_source #(
    parameter int HALF  = 36,
    parameter int FALLS = 5
) (
    input wire logic mclk,
    input wire logic go,
    output logic     pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        pin = 1'b1;
        forever begin
            @(posedge go);
            // each level held three standard machine cycles so no fall is lost
            repeat (FALLS) begin
                repeat (HALF) @(negedge mclk);
                pin = 1'b0;
                repeat (HALF) @(negedge mclk);
                pin = 1'b1;
            end
        end
    end
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the dual timer/counter
// assumes tmr_pkg and the design compiled first
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import tmr_pkg::*;
    localparam int N_FALLS = 5;
    logic mclk = 1'b0, rstn = 1'b0, run0 = 1'b0, run1 = 1'b0, go = 1'b0, pin0, pin1;
    logic [1:0] vack = 2'h0;
    logic [5:0] wr_sel = 6'h00;
    logic [7:0] wr_data = 8'h00, h0, l0, h1, l1, mreg, creg, regs [6];
    logic f0, f1;
    int err_total = 0, cmp_count = 0;
    logic [7:0] row_d [6] = '{8'h44, 8'h18, 8'h5a, 8'ha5, 8'h3c, 8'hc3};
    // ********
    // design and partner
    // ********
    dual_timer_counter dut_u (.mclk, .rstn, .wr_data, .counter_mode_register_wr(wr_sel[0]),
        .clock_control_register_wr(wr_sel[1]), .cnt0_high_byte_wr(wr_sel[2]), .cnt0_low_byte_wr(wr_sel[3]),
        .cnt1_high_byte_wr(wr_sel[4]), .cnt1_low_byte_wr(wr_sel[5]), .run_control_bit_0(run0),
        .run_control_bit_1(run1), .vector_ack_0(vack[0]), .vector_ack_1(vack[1]), .count_pin_0(pin0),
        .count_pin_1(pin1), .cnt0_high_byte(h0), .cnt0_low_byte(l0), .cnt1_high_byte(h1), .cnt1_low_byte(l1),
        .counter_mode_register(mreg), .clock_control_register(creg), .overflow_flag_0(f0), .overflow_flag_1(f1));
    pin_source #(.HALF(36), .FALLS(N_FALLS)) src_u (.mclk, .go, .pin(pin1));
    pin_source #(.HALF(36), .FALLS(N_FALLS)) src0_u (.mclk, .go, .pin(pin0));
    always_comb regs = '{mreg, creg, h0, l0, h1, l1};
    initial forever #10 mclk = ~mclk;
    // ********
    // tasks
    // ********
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input int sel, input logic [7:0] d);
        @(negedge mclk);
        wr_data = d;
        wr_sel = 6'(1 << sel);
        @(negedge mclk);
        wr_sel = 6'h00;
    endtask
    // run for n edges: every n that is a multiple of 4 or 12 holds exactly n/4 or n/12 ticks
    task run_for(input logic r0, input logic r1, input int n);
        @(negedge mclk);
        run0 = r0;
        run1 = r1;
        repeat (n) @(negedge mclk);
        run0 = 1'b0;
        run1 = 1'b0;
    endtask
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
    // ********
    // tests
    // ********
    initial begin
        repeat (3) @(negedge mclk);
        for (int i = 0; i < 6; i++) chk(regs[i], 8'h00);
        rstn = 1'b1;
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            wr(i, row_d[i]);
            chk(regs[i], row_d[i]);
        end
        $display("register test done");
        wr(0, 8'h10);
        wr(1, 8'h08);
        for (int i = 2; i < 6; i++) wr(i, 8'h00);
        run_for(1'b1, 1'b1, 48);
        chk(l0, 8'h0c);
        chk(l1, 8'h04);
        wr(2, 8'hff);
        wr(3, 8'hff);
        wr(4, 8'hff);
        wr(5, 8'hff);
        run_for(1'b1, 1'b1, 12);
        chk(l0, 8'he2);
        chk(h0, 8'h00);
        chk({7'h0, f0}, 8'h01);
        chk(l1, 8'h00);
        chk(h1, 8'h00);
        chk({7'h0, f1}, 8'h01);
        repeat (40) @(negedge mclk);
        chk(l0, 8'he2);
        vack = 2'h3;
        @(negedge mclk);
        vack = 2'h0;
        chk({7'h0, f0}, 8'h00);
        chk({7'h0, f1}, 8'h00);
        $display("timer test done");
        wr(0, 8'h44);
        wr(3, 8'h00);
        wr(5, 8'h00);
        run0 = 1'b1;
        run1 = 1'b1;
        go = 1'b1;
        repeat (440) @(negedge mclk);
        run0 = 1'b0;
        run1 = 1'b0;
        go = 1'b0;
        chk(l0, 8'(N_FALLS));
        chk(l1, 8'(N_FALLS));
        $display("counter test done");
        finish_test();
    end
endmodule
bind dual_timer_counter dual_timer_counter_properties chk_u (.mclk, .rstn, .counter_mode_register_wr,
    .clock_control_register_wr, .cnt0_high_byte_wr, .cnt0_low_byte_wr, .run_control_bit_0, .vector_ack_0, .vector_ack_1,
    .wr_data, .cnt0_high_byte, .cnt0_low_byte, .cnt1_high_byte, .counter_mode_register,
    .clock_control_register, .overflow_flag_0, .overflow_flag_1);
